// ==== core/rsc_counter.v ====
// saturating-free wrapping counter with variable increment
`timescale 1ns/100ps
module rsc_counter #(
    parameter WIDTH = 32,
    parameter INC_W = 14
) (
    input wire sys_clk,
    input wire rst_n,
    input wire inc_en,
    input wire [INC_W-1:0] inc_val,
    output wire [WIDTH-1:0] count
);
    reg [WIDTH-1:0] cnt_ff;
    wire [WIDTH-1:0] nxt_cnt;

    assign nxt_cnt = cnt_ff + {{(WIDTH-INC_W){1'b0}}, inc_val};
    assign count = cnt_ff;

    always @(posedge sys_clk) begin
        if (!rst_n) begin
            cnt_ff <= {WIDTH{1'b0}};
        end else if (inc_en) begin
            cnt_ff <= nxt_cnt;
        end
    end
endmodule // rsc_counter

// ==== core/rsc_regs.vh ====
// constants for the per-port statistics counter block
`ifndef RSC_REGS_VH
`define RSC_REGS_VH
`define RSC_MIN_FRAME 14'h0040
`define RSC_MAX_UNTAGGED 14'h05EE
`define RSC_MAX_TAGGED 14'h05F2
`define RSC_B127 14'h007F
`define RSC_B255 14'h00FF
`define RSC_B511 14'h01FF
`define RSC_B1023 14'h03FF
`define RSC_MAX_ATTEMPTS 5'h10
`define RSC_LATE_BYTES 14'h0040
// counter indices on the flat counter bus
`define RSC_C_DROP 0
`define RSC_C_OCTETS 1
`define RSC_C_BCAST 2
`define RSC_C_MCAST 3
`define RSC_C_CRCALIGN 4
`define RSC_C_UNDERSIZE 5
`define RSC_C_OVERSIZE 6
`define RSC_C_FRAGMENT 7
`define RSC_C_JABBER 8
`define RSC_C_COLLISION 9
`define RSC_C_H64 10
`define RSC_C_H127 11
`define RSC_C_H255 12
`define RSC_C_H511 13
`define RSC_C_H1023 14
`define RSC_C_H1518 15
`define RSC_C_PAUSE_RX 16
`define RSC_C_PAUSE_TX 17
`define RSC_C_UCAST_TX 18
`define RSC_C_NUCAST_TX 19
`define RSC_C_SEND_FAIL 20
`define RSC_NUM_CNT 21
`endif

// ==== core/rsc_stats.v ====
// per-port rmon statistics counters fed by mac status strobes
`timescale 1ns/100ps
`include "rsc_regs.vh"
// Contract
// - count every discard caused by buffer or resource shortage, except one flagged with drop_red in the same cycle
// - quality-of-service random early discards never reach the drop counter
// - add byte length of every received frame, good or bad, to octets
// - count good forwarded broadcast frames only, not other multicast
// - count good forwarded multicast frames, excluding broadcast
// - crc/align errors, no collision, 64 up to below max length
// - undersize: below 64 bytes, good checksum, no framing error, no collision
// - oversize: above max length, no collision, errors ignored
// - fragments: below 64 bytes, bad checksum, no collision
// - jabbers: above max length, bad checksum, no collision
// - count every collision seen while transmitting
// - six histogram bins 64,65-127,128-255,256-511,512-1023,1024-1518
// - histogram counts good and errored frames alike
// - separate received and transmitted pause frame counters
// - separate unicast and non-unicast transmit counters
// - broadcast or multicast transmit destination counts as non-unicast
// - send fail on underrun, late collision, or sixteenth collision
// - collision after 64 transmitted bytes is late, also counted normally
module rsc_stats #(
    parameter CNT_W = 32,
    parameter LEN_W = 14
) (
    input wire sys_clk,
    input wire rst_n,
    // receive frame status, one pulse per frame end
    input wire rx_done,
    input wire [LEN_W-1:0] rx_len,
    input wire rx_tagged,
    input wire rx_fcs_err,
    input wire rx_align_err,
    input wire rx_collision,
    input wire rx_bcast,
    input wire rx_mcast,
    input wire rx_pause,
    input wire rx_forwarded,
    // queue manager drop events
    input wire drop_resource,
    input wire drop_red,
    // transmit status
    input wire tx_done,
    input wire tx_bcast,
    input wire tx_mcast,
    input wire tx_pause,
    input wire tx_collision,
    input wire [LEN_W-1:0] tx_byte_cnt,
    input wire tx_underrun,
    output wire [CNT_W*`RSC_NUM_CNT-1:0] counters,
    output reg late_coll_ff,
    output reg [4:0] attempt_ff
);
    localparam NC = `RSC_NUM_CNT;

    // registered frame snapshot keeps the counter adders off the mac timing path
    reg rx_v_ff;
    reg [LEN_W-1:0] rx_len_ff;
    reg tag_ff, fcs_ff, aln_ff, col_ff, bc_ff, mc_ff, pause_ff, fwd_ff;
    reg drop_ff;
    reg txd_ff, txbc_ff, txmc_ff, txp_ff, txcol_ff, txund_ff;
    reg [LEN_W-1:0] txcnt_ff;

    reg [NC-1:0] inc;
    reg [LEN_W-1:0] inc_val [0:NC-1];
    reg [4:0] nxt_attempt;
    reg nxt_late;
    wire long_f;
    wire short_f;
    wire maxlen_f;
    wire good_f;
    wire late_now;
    wire fail_now;
    integer i;

    function in_range;
        input [LEN_W-1:0] len;
        input [LEN_W-1:0] lo;
        input [LEN_W-1:0] hi;
        begin
            in_range = (len >= lo) && (len <= hi);
        end
    endfunction

    always @(posedge sys_clk) begin
        if (!rst_n) begin
            rx_v_ff <= 1'b0;
            rx_len_ff <= {LEN_W{1'b0}};
            tag_ff <= 1'b0;
            fcs_ff <= 1'b0;
            aln_ff <= 1'b0;
            col_ff <= 1'b0;
            bc_ff <= 1'b0;
            mc_ff <= 1'b0;
            pause_ff <= 1'b0;
            fwd_ff <= 1'b0;
            drop_ff <= 1'b0;
            txd_ff <= 1'b0;
            txbc_ff <= 1'b0;
            txmc_ff <= 1'b0;
            txp_ff <= 1'b0;
            txcol_ff <= 1'b0;
            txund_ff <= 1'b0;
            txcnt_ff <= {LEN_W{1'b0}};
        end else begin
            rx_v_ff <= rx_done;
            rx_len_ff <= rx_len;
            tag_ff <= rx_tagged;
            fcs_ff <= rx_fcs_err;
            aln_ff <= rx_align_err;
            col_ff <= rx_collision;
            bc_ff <= rx_bcast;
            mc_ff <= rx_mcast;
            pause_ff <= rx_pause;
            fwd_ff <= rx_forwarded;
            drop_ff <= drop_resource & ~drop_red;
            txd_ff <= tx_done;
            txbc_ff <= tx_bcast;
            txmc_ff <= tx_mcast;
            txp_ff <= tx_pause;
            txcol_ff <= tx_collision;
            txund_ff <= tx_underrun;
            txcnt_ff <= tx_byte_cnt;
        end
    end

    assign maxlen_f = tag_ff ? (rx_len_ff > `RSC_MAX_TAGGED) :
                               (rx_len_ff > `RSC_MAX_UNTAGGED);
    assign long_f = maxlen_f;
    assign short_f = rx_len_ff < `RSC_MIN_FRAME;
    assign good_f = ~fcs_ff & ~aln_ff & ~col_ff;
    // collision past the slot is late; the sixteenth attempt also abandons
    assign late_now = txcol_ff && (txcnt_ff > `RSC_LATE_BYTES);
    assign fail_now = txund_ff | late_now |
                      (txcol_ff && (attempt_ff == (`RSC_MAX_ATTEMPTS - 5'h01)));

    always @* begin
        inc = {NC{1'b0}};
        for (i = 0; i < NC; i = i + 1) begin
            inc_val[i] = {{(LEN_W-1){1'b0}}, 1'b1};
        end
        inc[`RSC_C_DROP] = drop_ff;
        inc[`RSC_C_OCTETS] = rx_v_ff;
        inc_val[`RSC_C_OCTETS] = rx_len_ff;
        inc[`RSC_C_BCAST] = rx_v_ff & good_f & fwd_ff & bc_ff;
        inc[`RSC_C_MCAST] = rx_v_ff & good_f & fwd_ff & mc_ff & ~bc_ff;
        inc[`RSC_C_CRCALIGN] = rx_v_ff & ~col_ff & (fcs_ff | aln_ff) & ~short_f &
            (tag_ff ? (rx_len_ff < `RSC_MAX_TAGGED) :
                      (rx_len_ff < `RSC_MAX_UNTAGGED));
        inc[`RSC_C_UNDERSIZE] = rx_v_ff & short_f & good_f;
        inc[`RSC_C_OVERSIZE] = rx_v_ff & ~col_ff & long_f;
        inc[`RSC_C_FRAGMENT] = rx_v_ff & ~col_ff & short_f & fcs_ff;
        inc[`RSC_C_JABBER] = rx_v_ff & ~col_ff & long_f & fcs_ff;
        inc[`RSC_C_COLLISION] = txcol_ff;
        // histogram takes every frame of 64 to 1518 bytes regardless of error flags
        inc[`RSC_C_H64] = rx_v_ff & (rx_len_ff == `RSC_MIN_FRAME);
        inc[`RSC_C_H127] = rx_v_ff &
            in_range(rx_len_ff, `RSC_MIN_FRAME + 14'h0001, `RSC_B127);
        inc[`RSC_C_H255] = rx_v_ff &
            in_range(rx_len_ff, `RSC_B127 + 14'h0001, `RSC_B255);
        inc[`RSC_C_H511] = rx_v_ff &
            in_range(rx_len_ff, `RSC_B255 + 14'h0001, `RSC_B511);
        inc[`RSC_C_H1023] = rx_v_ff &
            in_range(rx_len_ff, `RSC_B511 + 14'h0001, `RSC_B1023);
        inc[`RSC_C_H1518] = rx_v_ff &
            in_range(rx_len_ff, `RSC_B1023 + 14'h0001, `RSC_MAX_UNTAGGED);
        inc[`RSC_C_PAUSE_RX] = rx_v_ff & pause_ff;
        inc[`RSC_C_PAUSE_TX] = txd_ff & txp_ff;
        inc[`RSC_C_UCAST_TX] = txd_ff & ~txbc_ff & ~txmc_ff;
        inc[`RSC_C_NUCAST_TX] = txd_ff & (txbc_ff | txmc_ff);
        inc[`RSC_C_SEND_FAIL] = fail_now;
    end

    // attempt count per frame; cleared when the frame completes or is abandoned
    always @* begin
        nxt_attempt = attempt_ff;
        nxt_late = late_coll_ff;
        if (txd_ff | fail_now) begin
            nxt_attempt = 5'h00;
        end else if (txcol_ff) begin
            nxt_attempt = attempt_ff + 5'h01;
        end
        nxt_late = late_now;
    end

    always @(posedge sys_clk) begin
        if (!rst_n) begin
            attempt_ff <= 5'h00;
            late_coll_ff <= 1'b0;
        end else begin
            attempt_ff <= nxt_attempt;
            late_coll_ff <= nxt_late;
        end
    end

    // one named instance per counter so each count is easy to find in the hierarchy
    rsc_counter #(.WIDTH(CNT_W), .INC_W(LEN_W)) u_cnt_drop (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .inc_en(inc[`RSC_C_DROP]),
        .inc_val(inc_val[`RSC_C_DROP]),
        .count(counters[`RSC_C_DROP*CNT_W +: CNT_W])
    );
    rsc_counter #(.WIDTH(CNT_W), .INC_W(LEN_W)) u_cnt_octets (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .inc_en(inc[`RSC_C_OCTETS]),
        .inc_val(inc_val[`RSC_C_OCTETS]),
        .count(counters[`RSC_C_OCTETS*CNT_W +: CNT_W])
    );
    rsc_counter #(.WIDTH(CNT_W), .INC_W(LEN_W)) u_cnt_bcast (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .inc_en(inc[`RSC_C_BCAST]),
        .inc_val(inc_val[`RSC_C_BCAST]),
        .count(counters[`RSC_C_BCAST*CNT_W +: CNT_W])
    );
    rsc_counter #(.WIDTH(CNT_W), .INC_W(LEN_W)) u_cnt_mcast (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .inc_en(inc[`RSC_C_MCAST]),
        .inc_val(inc_val[`RSC_C_MCAST]),
        .count(counters[`RSC_C_MCAST*CNT_W +: CNT_W])
    );
    rsc_counter #(.WIDTH(CNT_W), .INC_W(LEN_W)) u_cnt_crcalign (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .inc_en(inc[`RSC_C_CRCALIGN]),
        .inc_val(inc_val[`RSC_C_CRCALIGN]),
        .count(counters[`RSC_C_CRCALIGN*CNT_W +: CNT_W])
    );
    rsc_counter #(.WIDTH(CNT_W), .INC_W(LEN_W)) u_cnt_undersize (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .inc_en(inc[`RSC_C_UNDERSIZE]),
        .inc_val(inc_val[`RSC_C_UNDERSIZE]),
        .count(counters[`RSC_C_UNDERSIZE*CNT_W +: CNT_W])
    );
    rsc_counter #(.WIDTH(CNT_W), .INC_W(LEN_W)) u_cnt_oversize (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .inc_en(inc[`RSC_C_OVERSIZE]),
        .inc_val(inc_val[`RSC_C_OVERSIZE]),
        .count(counters[`RSC_C_OVERSIZE*CNT_W +: CNT_W])
    );
    rsc_counter #(.WIDTH(CNT_W), .INC_W(LEN_W)) u_cnt_fragment (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .inc_en(inc[`RSC_C_FRAGMENT]),
        .inc_val(inc_val[`RSC_C_FRAGMENT]),
        .count(counters[`RSC_C_FRAGMENT*CNT_W +: CNT_W])
    );
    rsc_counter #(.WIDTH(CNT_W), .INC_W(LEN_W)) u_cnt_jabber (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .inc_en(inc[`RSC_C_JABBER]),
        .inc_val(inc_val[`RSC_C_JABBER]),
        .count(counters[`RSC_C_JABBER*CNT_W +: CNT_W])
    );
    rsc_counter #(.WIDTH(CNT_W), .INC_W(LEN_W)) u_cnt_collision (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .inc_en(inc[`RSC_C_COLLISION]),
        .inc_val(inc_val[`RSC_C_COLLISION]),
        .count(counters[`RSC_C_COLLISION*CNT_W +: CNT_W])
    );
    rsc_counter #(.WIDTH(CNT_W), .INC_W(LEN_W)) u_cnt_h64 (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .inc_en(inc[`RSC_C_H64]),
        .inc_val(inc_val[`RSC_C_H64]),
        .count(counters[`RSC_C_H64*CNT_W +: CNT_W])
    );
    rsc_counter #(.WIDTH(CNT_W), .INC_W(LEN_W)) u_cnt_h127 (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .inc_en(inc[`RSC_C_H127]),
        .inc_val(inc_val[`RSC_C_H127]),
        .count(counters[`RSC_C_H127*CNT_W +: CNT_W])
    );
    rsc_counter #(.WIDTH(CNT_W), .INC_W(LEN_W)) u_cnt_h255 (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .inc_en(inc[`RSC_C_H255]),
        .inc_val(inc_val[`RSC_C_H255]),
        .count(counters[`RSC_C_H255*CNT_W +: CNT_W])
    );
    rsc_counter #(.WIDTH(CNT_W), .INC_W(LEN_W)) u_cnt_h511 (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .inc_en(inc[`RSC_C_H511]),
        .inc_val(inc_val[`RSC_C_H511]),
        .count(counters[`RSC_C_H511*CNT_W +: CNT_W])
    );
    rsc_counter #(.WIDTH(CNT_W), .INC_W(LEN_W)) u_cnt_h1023 (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .inc_en(inc[`RSC_C_H1023]),
        .inc_val(inc_val[`RSC_C_H1023]),
        .count(counters[`RSC_C_H1023*CNT_W +: CNT_W])
    );
    rsc_counter #(.WIDTH(CNT_W), .INC_W(LEN_W)) u_cnt_h1518 (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .inc_en(inc[`RSC_C_H1518]),
        .inc_val(inc_val[`RSC_C_H1518]),
        .count(counters[`RSC_C_H1518*CNT_W +: CNT_W])
    );
    rsc_counter #(.WIDTH(CNT_W), .INC_W(LEN_W)) u_cnt_pause_rx (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .inc_en(inc[`RSC_C_PAUSE_RX]),
        .inc_val(inc_val[`RSC_C_PAUSE_RX]),
        .count(counters[`RSC_C_PAUSE_RX*CNT_W +: CNT_W])
    );
    rsc_counter #(.WIDTH(CNT_W), .INC_W(LEN_W)) u_cnt_pause_tx (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .inc_en(inc[`RSC_C_PAUSE_TX]),
        .inc_val(inc_val[`RSC_C_PAUSE_TX]),
        .count(counters[`RSC_C_PAUSE_TX*CNT_W +: CNT_W])
    );
    rsc_counter #(.WIDTH(CNT_W), .INC_W(LEN_W)) u_cnt_ucast_tx (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .inc_en(inc[`RSC_C_UCAST_TX]),
        .inc_val(inc_val[`RSC_C_UCAST_TX]),
        .count(counters[`RSC_C_UCAST_TX*CNT_W +: CNT_W])
    );
    rsc_counter #(.WIDTH(CNT_W), .INC_W(LEN_W)) u_cnt_nucast_tx (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .inc_en(inc[`RSC_C_NUCAST_TX]),
        .inc_val(inc_val[`RSC_C_NUCAST_TX]),
        .count(counters[`RSC_C_NUCAST_TX*CNT_W +: CNT_W])
    );
    rsc_counter #(.WIDTH(CNT_W), .INC_W(LEN_W)) u_cnt_send_fail (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .inc_en(inc[`RSC_C_SEND_FAIL]),
        .inc_val(inc_val[`RSC_C_SEND_FAIL]),
        .count(counters[`RSC_C_SEND_FAIL*CNT_W +: CNT_W])
    );
endmodule // rsc_stats

// ==== tb/rsc_mac_model.sv ====
// behavioural source of mac and queue status strobes
`timescale 1ns/100ps
module rsc_mac_model (
    input wire sys_clk,
    output reg [13:0] len = 14'h0000,
    output reg [7:0] rxq = 8'h00,
    output reg [2:0] txq = 3'h0,
    output reg [5:0] st = 6'h00
);
    // qualifiers go inverted after the strobe so stale values never pass as valid
    task send(input [13:0] l, input [7:0] q, input [2:0] t, input [5:0] s);
        begin
            @(posedge sys_clk) #1;
            {len, rxq, txq, st} = {l, q, t, s};
            @(posedge sys_clk) #1;
            {len, rxq, txq, st} = {~l, ~q, ~t, 6'h00};
        end
    endtask
endmodule // rsc_mac_model

// ==== tb/rsc_stats_assertions.sv ====
// concurrent checks on the statistics counter block ports
`timescale 1ns/100ps
module rsc_stats_assertions (
    input wire sys_clk,
    input wire rst_n,
    input wire rx_done,
    input wire rx_bcast,
    input wire drop_resource,
    input wire drop_red,
    input wire tx_collision,
    input wire tx_underrun,
    input wire [13:0] rx_len,
    input wire [13:0] tx_byte_cnt,
    input wire [671:0] counters
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    wire [31:0] cd = counters[31:0];
    wire [31:0] co = counters[63:32];
    wire [31:0] cm = counters[127:96];
    wire [31:0] cc = counters[319:288];
    wire [31:0] ch = counters[351:320];
    wire [31:0] cs = counters[671:640];
    property p_drop; drop_resource && !drop_red |-> ##2 cd == $past(cd) + 1; endproperty
    a_drop: assert property (p_drop) else $error("drop missed");
    property p_red; drop_resource && drop_red |-> ##2 $stable(cd); endproperty
    a_red: assert property (p_red) else $error("early discard counted");
    property p_oct; rx_done |-> ##2 co == $past(co) + $past(rx_len, 2); endproperty
    a_oct: assert property (p_oct) else $error("octets wrong");
    property p_mc; rx_done && rx_bcast |-> ##2 $stable(cm); endproperty
    a_mc: assert property (p_mc) else $error("broadcast in multicast");
    property p_h64; rx_done && rx_len == 14'h0040 |-> ##2 ch == $past(ch) + 1; endproperty
    a_h64: assert property (p_h64) else $error("bin 64 missed");
    property p_col; tx_collision |-> ##2 cc == $past(cc) + 1; endproperty
    a_col: assert property (p_col) else $error("collision missed");
    property p_und; tx_underrun |-> ##2 cs == $past(cs) + 1; endproperty
    a_und: assert property (p_und) else $error("underrun missed");
    property p_late;
        tx_collision && tx_byte_cnt > 14'h0040 |-> ##2 cs == $past(cs) + 1;
    endproperty
    a_late: assert property (p_late) else $error("late collision missed");
endmodule // rsc_stats_assertions
bind rsc_stats rsc_stats_assertions i_rsc_stats_assertions (.*);

// ==== tb/rsc_stats_tb_top.sv ====
// self-checking bench for the statistics counter block
`timescale 1ns/100ps
module rsc_stats_tb_top;
    reg sys_clk = 1'b0;
    reg rst_n = 1'b0;
    wire [13:0] len;
    wire [7:0] q;
    wire [2:0] x;
    wire [5:0] e;
    wire [671:0] cnt;
    reg [31:0] s [0:20];
    reg [42:0] rw [0:15];
    wire late;
    wire [4:0] att;
    integer err_count = 0, num_checks = 0, i, k, att_exp = 0, cyc = 0;
    rsc_mac_model i_rsc_mac_model (.sys_clk(sys_clk), .len(len), .rxq(q), .txq(x), .st(e));
    rsc_stats i_rsc_stats (.sys_clk(sys_clk), .rst_n(rst_n), .rx_done(e[5]), .rx_len(len),
        .rx_tagged(q[5]), .rx_fcs_err(q[4]), .rx_align_err(q[3]), .rx_collision(q[2]),
        .rx_bcast(q[1]), .rx_mcast(q[0]), .rx_pause(q[6]), .rx_forwarded(q[7]),
        .drop_resource(e[1]), .drop_red(e[0]), .tx_done(e[4]), .tx_bcast(x[2]), .tx_mcast(x[1]),
        .tx_pause(x[0]), .tx_collision(e[3]), .tx_byte_cnt(len), .tx_underrun(e[2]),
        .counters(cnt), .late_coll_ff(late), .attempt_ff(att));
    task chk(input [31:0] got, input [31:0] exp, input integer id);
        begin
            num_checks = num_checks + 1;
            if (got !== exp) begin
                err_count = err_count + 1;
                $display("ERROR counter %0d expected %0d seen %0d", id, exp, got);
            end
        end
    endtask
    // every counter is compared each step so a stray increment anywhere shows
    task go(input [13:0] l, input [7:0] rq, input [2:0] tq, input [5:0] st, input [20:0] m);
        begin
            i_rsc_mac_model.send(l, rq, tq, st);
            @(posedge sys_clk) #1;
            // late flag stands for one cycle only, so it is looked at here
            chk({31'h0, late}, {31'h0, st[3] && l > 14'h0040}, 21);
            if (st[4] || st[2] || (st[3] && (l > 14'h0040 || att_exp == 15)))
                att_exp = 0;
            else if (st[3])
                att_exp = att_exp + 1;
            chk({27'h0, att}, att_exp, 22);
            @(posedge sys_clk) #1;
            for (k = 0; k < 21; k = k + 1) begin
                chk(cnt[k*32+:32] - s[k],
                    {18'h0, k == 1 ? l & {14{st[5]}} : {13'h0, m[k]}}, k);
                s[k] = cnt[k*32+:32];
            end
        end
    endtask
    task close_out;
        begin
            $display("checks %0d mismatches %0d", num_checks, err_count);
            if (err_count == 0 && num_checks > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    // ceiling well above the 184 or so cycles the sequence needs
    always @(posedge sys_clk) begin
        cyc = cyc + 1;
        if (cyc == 4000) begin
            err_count = err_count + 1;
            close_out;
        end
    end
    initial begin
        rw[0] = {14'h0040, 8'hC2, 21'h010404};
        rw[1] = {14'h003F, 8'h80, 21'h000020};
        rw[2] = {14'h003F, 8'h90, 21'h000080};
        rw[3] = {14'h05EE, 8'h90, 21'h008000};
        rw[4] = {14'h05EF, 8'h90, 21'h000140};
        rw[5] = {14'h05EF, 8'hB0, 21'h000010};
        rw[6] = {14'h007F, 8'h81, 21'h000808};
        rw[7] = {14'h0028, 8'h88, 21'h000000};
        rw[8] = {14'h00C8, 8'h80, 21'h001000};
        rw[9] = {14'h012C, 8'h02, 21'h002000};
        rw[10] = {14'h0258, 8'h94, 21'h004000};
        rw[11] = {14'h05F3, 8'hA0, 21'h000040};
        rw[12] = {14'h0400, 8'h83, 21'h008004};
        rw[13] = {14'h003F, 8'h84, 21'h000000};
        rw[14] = {14'h03FF, 8'h80, 21'h004000};
        rw[15] = {14'h0041, 8'h81, 21'h000808};
        for (k = 0; k < 21; k = k + 1)
            s[k] = 32'h0;
        repeat (12) @(posedge sys_clk) #1;
        rst_n = 1'b1;
        go(14'h0, 8'h0, 3'h0, 6'h0, 21'h0);
        for (i = 0; i < 16; i = i + 1)
            go(rw[i][42:29], rw[i][28:21], 3'h0, 6'h20,
                rw[i][20:0]);
        $display("frame rows done");
        go(14'h0, 8'h0, 3'h4, 6'h10, 21'h080000);
        go(14'h0, 8'h0, 3'h3, 6'h10, 21'h0A0000);
        go(14'h0, 8'h0, 3'h0, 6'h03, 21'h000000);
        go(14'h0, 8'h0, 3'h0, 6'h02, 21'h000001);
        go(14'h0040, 8'h0, 3'h0, 6'h08, 21'h000200);
        go(14'h0041, 8'h0, 3'h0, 6'h0C, 21'h100200);
        go(14'h0, 8'h0, 3'h0, 6'h10, 21'h040000);
        for (i = 0; i < 16; i = i + 1)
            go(14'h000A, 8'h0, 3'h0, 6'h08, i == 15 ? 21'h100200 : 21'h000200);
        $display("transmit tests done");
        go(14'h000A, 8'h0, 3'h0, 6'h08, 21'h000200);
        // mid-run reset with events pulsed while it is held
        rst_n = 1'b0;
        i_rsc_mac_model.send(14'h0040, 8'h80, 3'h0, 6'h2E);
        rst_n = 1'b1;
        repeat (2) @(posedge sys_clk) #1;
        chk({27'h0, att}, 32'h0, 22);
        chk({31'h0, late}, 32'h0, 21);
        for (k = 0; k < 21; k = k + 1) begin
            chk(cnt[k*32+:32], 32'h0, k);
            s[k] = 32'h0;
        end
        att_exp = 0;
        go(14'h0040, 8'h80, 3'h0, 6'h20, 21'h000400);
        $display("reset test done");
        close_out;
    end
endmodule // rsc_stats_tb_top
